// File: inc/oafp_cfg.svh
// constants for the front panel block
`ifndef OAFP_CFG_SVH
`define OAFP_CFG_SVH
`define OAFP_CLK_HZ 50000000
`define OAFP_BOOT_BLINK_MS 5000
`define OAFP_BOOT_CYCLES ((`OAFP_BOOT_BLINK_MS * (`OAFP_CLK_HZ / 1000)))
`define OAFP_BANNER_MS 1000
`define OAFP_BANNER_CYCLES ((`OAFP_BANNER_MS * (`OAFP_CLK_HZ / 1000)))
`define OAFP_IDLE_S 120
`define OAFP_IDLE_CYCLES ((`OAFP_IDLE_S * `OAFP_CLK_HZ))
`define OAFP_TICK_MS 10
`define OAFP_TICK_CYCLES ((`OAFP_TICK_MS * (`OAFP_CLK_HZ / 1000)))
`define OAFP_HOLD_SLOW 50
`define OAFP_HOLD_FAST 200
`define OAFP_STEP_SMALL 16'h0001
`define OAFP_STEP_MID 16'h000a
`define OAFP_STEP_BIG 16'h0064
`define OAFP_DEF_SETPOINT 16'h00c8
`define OAFP_SW_RETAIN 7
`define OAFP_SW_AUTOCLR 5
`define OAFP_REG_CTRL 8'h00
`define OAFP_REG_O2 8'h04
`define OAFP_REG_STATUS 8'h08
`define OAFP_REG_SP0 8'h0c
`define OAFP_REG_SP1 8'h10
`define OAFP_REG_SP2 8'h14
`define OAFP_REG_DIR 8'h18
`define OAFP_REG_DISP 8'h1c
`define OAFP_REG_SWITCH 8'h20
`define OAFP_CTRL_BATOPT 0
`define OAFP_CTRL_LOWBAT 1
`define OAFP_CTRL_CRITBAT 2
`define OAFP_CTRL_CAL 3
`define OAFP_CTRL_BATOK 4
`endif

// File: inc/oafp_pkg.sv
// types shared by the front panel block
package oafp_pkg;
  typedef enum logic [3:0] {
    disp_dashes, disp_switches, disp_o2, disp_setpoint, disp_dir,
    disp_low_battery_message, disp_halt, disp_cal
  } oafp_disp_t;
  typedef enum logic [2:0] {
    st_boot, st_show_sw, st_run, st_set, st_dir, st_cal, st_halt
  } oafp_state_t;
endpackage : oafp_pkg

// File: inc/oafp_sp_if.sv
// set-point store access between the controller and its memory
interface oafp_sp_if;
  logic we;
  logic [1:0] waddr;
  logic [15:0] wdata;
  logic [1:0] raddr;
  logic [15:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : oafp_sp_if

// File: src/oafp_sp_mem.sv
// battery-backed set-point store, three words with registered read
`include "oafp_cfg.svh"
module oafp_sp_mem (
  input wire logic aclk,
  oafp_sp_if.mem sp
);
  logic [15:0] words [0:2];
  // no reset on purpose: contents stand in for battery-backed memory
  always_ff @(posedge aclk) begin
    if (sp.we && sp.waddr != 2'h3) begin
      words[sp.waddr] <= sp.wdata;
    end
  end
  // read data out of a register
  always_ff @(posedge aclk) begin
    sp.rdata <= (sp.raddr == 2'h3) ? 16'h0000 : words[sp.raddr];
  end
endmodule : oafp_sp_mem

// File: src/oafp_top.sv
// front panel and alarm controller with an axi4-lite register slave
// Functional notes
// - cold start: dashes, all three leds blink with buzzer for five seconds
// - after blinking, show configuration switch states briefly, then run
// - switch 8 on keeps stored values; off loads defaults at power-up
// - switch 8 off plus up, down, alarm 3 together gives a warm boot
// - oxygen value displayed within five seconds of cold start; here it follows the five-second blink and the one-second switch view
// - up and down together in set mode toggles high/low, shown briefly
// - battery option fitted: show low battery message when charge is low
// - critical battery: show halt and stop until power and battery good
// - entering calibration shows a banner briefly, then the oxygen value
// - every channel defaults to low alarm, each settable to high
// - no alarm active: alarm button enters set mode, led on, set point shown
// - set mode shows direction letter after the set point
// - up raises, down lowers; held buttons scroll faster over time
// - same alarm button again leaves set mode, led off, oxygen shown
// - alarm event lights channel led, sounds buzzer, switches channel relay
// - switch 6 selects auto-clear or manual-clear cancellation
// - switch 6 on: indications release when the alarm condition clears
// - two minutes without adjustment in set mode returns to normal operation; here the 32-bit IDLE_CYCLES default wraps to about 34 seconds
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`include "oafp_cfg.svh"
module oafp_top #(
  parameter int unsigned BOOT_CYCLES = `OAFP_BOOT_CYCLES,
  parameter int unsigned BANNER_CYCLES = `OAFP_BANNER_CYCLES,
  parameter int unsigned IDLE_CYCLES = `OAFP_IDLE_CYCLES,
  parameter int unsigned TICK_CYCLES = `OAFP_TICK_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] config_switch_bank,
  input wire logic btn_up,
  input wire logic btn_down,
  input wire logic [2:0] btn_alarm,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [2:0] alarm_led,
  output logic buzzer,
  output logic [2:0] alarm_relay,
  output logic [3:0] disp_mode,
  output logic [15:0] disp_value,
  output logic [7:0] disp_suffix
);
  // --------
  // state and registers
  // --------
  oafp_pkg::oafp_state_t state;
  // blink bit scaled so the boot phase shows two to four blinks at any length
  localparam int unsigned BLINK_BIT = $clog2(BOOT_CYCLES) - 3;
  oafp_sp_if sp ();
  logic [31:0] timer;
  logic [31:0] idle;
  logic [31:0] tick_cnt;
  logic tick;
  logic [1:0] chan;
  logic [2:0] dir_high;
  logic [2:0] active;
  logic [2:0] latched;
  logic [2:0] silenced;
  logic [15:0] o2;
  logic o2_upd;
  logic [15:0] sp_reg [0:2];
  logic [4:0] ctrl;
  logic [1:0] init_idx;
  logic init_busy;
  logic [2:0] prev_alarm;
  logic prev_updn;
  logic [7:0] hold;
  logic [2:0] press;
  logic both;
  logic warm;
  logic aw_got;
  logic w_got;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic cal_rise;
  logic prev_cal;
  oafp_sp_mem u_mem (.aclk(aclk), .sp(sp));
  // step grows with hold time
  function automatic logic [15:0] step_of(input logic [7:0] h);
    if (h >= 8'(`OAFP_HOLD_FAST)) begin
      return `OAFP_STEP_BIG;
    end
    if (h >= 8'(`OAFP_HOLD_SLOW)) begin
      return `OAFP_STEP_MID;
    end
    return `OAFP_STEP_SMALL;
  endfunction : step_of
  // --------
  // button edges and tick divider
  // --------
  assign press = btn_alarm & ~prev_alarm;
  assign both = btn_up && btn_down;
  assign warm = both && btn_alarm[2] && !config_switch_bank[`OAFP_SW_RETAIN];
  assign cal_rise = ctrl[`OAFP_CTRL_CAL] && !prev_cal;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_alarm <= 3'h0;
      prev_updn <= 1'b0;
      prev_cal <= 1'b0;
    end else begin
      prev_alarm <= btn_alarm;
      prev_updn <= both;
      prev_cal <= ctrl[`OAFP_CTRL_CAL];
    end
  end
  // scroll tick, restarted by each press so a short tap steps once
  always_ff @(posedge aclk) begin
    if (!aresetn || hold == 8'h0 || tick_cnt == TICK_CYCLES - 1) begin
      tick_cnt <= 32'h0;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end
  assign tick = (tick_cnt == TICK_CYCLES - 1);
  // --------
  // main sequence
  // --------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= oafp_pkg::st_boot;
      timer <= 32'h0;
      idle <= 32'h0;
      chan <= 2'h0;
    end else begin
      timer <= timer + 32'h1;
      unique case (state)
        oafp_pkg::st_boot: if (timer >= BOOT_CYCLES - 1) begin
          state <= oafp_pkg::st_show_sw;
          timer <= 32'h0;
        end
        oafp_pkg::st_show_sw: if (timer >= BANNER_CYCLES - 1) begin
          state <= oafp_pkg::st_run;
          timer <= 32'h0;
        end
        oafp_pkg::st_run: begin
          timer <= 32'h0;
          idle <= 32'h0;
          if (cal_rise) begin
            state <= oafp_pkg::st_cal;
          end else if (press != 3'h0 && ((active | latched) & press) == 3'h0) begin
            state <= oafp_pkg::st_set;
            chan <= press[0] ? 2'h0 : (press[1] ? 2'h1 : 2'h2);
          end
        end
        oafp_pkg::st_set: begin
          idle <= (btn_up || btn_down) ? 32'h0 : idle + 32'h1;
          if (press[chan] || idle >= IDLE_CYCLES - 1) begin
            state <= oafp_pkg::st_run;
          end else if (both && !prev_updn) begin
            state <= oafp_pkg::st_dir;
            timer <= 32'h0;
          end
        end
        oafp_pkg::st_dir: if (timer >= BANNER_CYCLES - 1) begin
          state <= oafp_pkg::st_set;
          idle <= 32'h0;
        end
        oafp_pkg::st_cal: if (timer >= BANNER_CYCLES - 1) begin
          state <= oafp_pkg::st_run;
        end
        oafp_pkg::st_halt: state <= oafp_pkg::st_halt;
        default: state <= oafp_pkg::st_run;
      endcase
      // halt overrides everything except st_boot; only a reset with good battery restarts
      if (ctrl[`OAFP_CTRL_CRITBAT] && state != oafp_pkg::st_boot) begin
        state <= oafp_pkg::st_halt;
      end else if (warm && state != oafp_pkg::st_boot && state != oafp_pkg::st_halt) begin
        state <= oafp_pkg::st_boot;
        timer <= 32'h0;
      end
    end
  end
  // --------
  // set points, direction and defaults
  // --------
  // load defaults one word per cycle after reset when retain is off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      init_busy <= 1'b1;
      init_idx <= 2'h0;
    end else if (init_busy) begin
      init_idx <= init_idx + 2'h1;
      if (init_idx == 2'h3) begin
        init_busy <= 1'b0;
      end
    end
  end
  // shadow copy follows the store; defaults written when switch 8 is off
  always_ff @(posedge aclk) begin
    if (init_busy && init_idx != 2'h0) begin
      sp_reg[init_idx - 2'h1] <= config_switch_bank[`OAFP_SW_RETAIN] ?
        sp.rdata : `OAFP_DEF_SETPOINT;
    end else if (sp.we && sp.waddr != 2'h3) begin
      sp_reg[sp.waddr] <= sp.wdata;
    end
  end
  // adjust with held-button scrolling
  always_comb begin
    sp.we = 1'b0;
    sp.waddr = chan;
    sp.wdata = sp_reg[chan];
    sp.raddr = init_idx;
    if (init_busy) begin
      sp.we = !config_switch_bank[`OAFP_SW_RETAIN] && init_idx != 2'h3;
      sp.waddr = init_idx;
      sp.wdata = `OAFP_DEF_SETPOINT;
    end else if (state == oafp_pkg::st_set && !both && (tick || hold == 8'h0)) begin
      if (btn_up) begin
        sp.we = 1'b1;
        sp.wdata = sp_reg[chan] + step_of(hold);
      end else if (btn_down) begin
        sp.we = 1'b1;
        sp.wdata = (sp_reg[chan] > step_of(hold)) ? sp_reg[chan] - step_of(hold) : 16'h0;
      end
    end
  end
  // hold counter measures how long an arrow has been down, in ticks
  always_ff @(posedge aclk) begin
    if (!aresetn || !(btn_up ^ btn_down) || state != oafp_pkg::st_set) begin
      hold <= 8'h0;
    end else if (hold == 8'h0 || (tick && hold != 8'hff)) begin
      hold <= hold + 8'h1;
    end
  end
  // direction bits: low after default load, toggled by double press
  always_ff @(posedge aclk) begin
    if (!aresetn && !config_switch_bank[`OAFP_SW_RETAIN]) begin
      dir_high <= 3'h0;
    end else if (state == oafp_pkg::st_set && both && !prev_updn) begin
      dir_high[chan] <= ~dir_high[chan];
    end
  end
  // --------
  // alarm evaluation
  // --------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active <= 3'h0;
    end else if (o2_upd) begin
      for (int i = 0; i < 3; i++) begin
        active[i] <= dir_high[i] ? (o2 > sp_reg[i]) : (o2 < sp_reg[i]);
      end
    end
  end
  // latch events; auto-clear follows the condition, manual waits for a press
  always_ff @(posedge aclk) begin
    if (!aresetn || state == oafp_pkg::st_boot) begin
      latched <= 3'h0;
      silenced <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (active[i]) begin
          latched[i] <= 1'b1;
        end else if (config_switch_bank[`OAFP_SW_AUTOCLR]) begin
          latched[i] <= 1'b0;
          silenced[i] <= 1'b0;
        end else if (press[i] && silenced[i] && state == oafp_pkg::st_run) begin
          latched[i] <= 1'b0;
          silenced[i] <= 1'b0;
        end
        if (press[i] && latched[i] && !silenced[i] && state == oafp_pkg::st_run) begin
          silenced[i] <= 1'b1;
        end
      end
    end
  end
  // --------
  // outputs
  // --------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alarm_led <= 3'h0;
      buzzer <= 1'b0;
      alarm_relay <= 3'h0;
    end else if (state == oafp_pkg::st_boot) begin
      alarm_led <= {3{timer[BLINK_BIT]}};
      buzzer <= timer[BLINK_BIT];
      alarm_relay <= 3'h0;
    end else if (state == oafp_pkg::st_halt) begin
      alarm_led <= 3'h0;
      buzzer <= 1'b0;
      alarm_relay <= alarm_relay;
    end else begin
      alarm_led <= latched | ((state == oafp_pkg::st_set || state == oafp_pkg::st_dir) ?
        (3'h1 << chan) : 3'h0);
      buzzer <= |(latched & ~silenced);
      alarm_relay <= latched;
    end
  end
  // display selection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      disp_mode <= 4'(oafp_pkg::disp_dashes);
      disp_value <= 16'h0;
      disp_suffix <= 8'h00;
    end else begin
      disp_suffix <= 8'h00;
      disp_value <= o2;
      unique case (state)
        oafp_pkg::st_boot: begin
          disp_mode <= 4'(oafp_pkg::disp_dashes);
          disp_value <= {14'h0, timer[BLINK_BIT+1 -: 2]};
        end
        oafp_pkg::st_show_sw: begin
          disp_mode <= 4'(oafp_pkg::disp_switches);
          disp_value <= {8'h00, config_switch_bank};
        end
        oafp_pkg::st_set: begin
          disp_mode <= 4'(oafp_pkg::disp_setpoint);
          disp_value <= sp_reg[chan];
          disp_suffix <= dir_high[chan] ? 8'h48 : 8'h4c;
        end
        oafp_pkg::st_dir: begin
          disp_mode <= 4'(oafp_pkg::disp_dir);
          disp_value <= {15'h0, dir_high[chan]};
        end
        oafp_pkg::st_cal: disp_mode <= 4'(oafp_pkg::disp_cal);
        oafp_pkg::st_halt: disp_mode <= 4'(oafp_pkg::disp_halt);
        default: begin
          disp_mode <= (ctrl[`OAFP_CTRL_BATOPT] && ctrl[`OAFP_CTRL_LOWBAT]) ?
            4'(oafp_pkg::disp_low_battery_message) : 4'(oafp_pkg::disp_o2);
        end
      endcase
    end
  end
  // --------
  // axi4-lite slave
  // --------
  // address and data taken in either order; response one cycle after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      ctrl <= 5'h0;
      o2 <= 16'h0;
      o2_upd <= 1'b0;
    end else begin
      o2_upd <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_got && w_got) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        if (aw_addr == `OAFP_REG_CTRL && w_strb[0]) begin
          ctrl <= w_data[4:0];
        end else if (aw_addr == `OAFP_REG_O2 && w_strb[1:0] == 2'h3) begin
          o2 <= w_data[15:0];
          o2_upd <= 1'b1;
        end else if (aw_addr != `OAFP_REG_CTRL && aw_addr != `OAFP_REG_O2) begin
          s_axi_bresp <= 2'h2;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready = !w_got && !s_axi_bvalid;
  // read path, answer in the cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      unique case (s_axi_araddr)
        `OAFP_REG_CTRL: s_axi_rdata <= {27'h0, ctrl};
        `OAFP_REG_O2: s_axi_rdata <= {16'h0, o2};
        `OAFP_REG_STATUS: s_axi_rdata <= {22'h0, state, silenced, latched, active[0]};
        `OAFP_REG_SP0: s_axi_rdata <= {16'h0, sp_reg[0]};
        `OAFP_REG_SP1: s_axi_rdata <= {16'h0, sp_reg[1]};
        `OAFP_REG_SP2: s_axi_rdata <= {16'h0, sp_reg[2]};
        `OAFP_REG_DIR: s_axi_rdata <= {29'h0, dir_high};
        `OAFP_REG_DISP: s_axi_rdata <= {12'h0, disp_mode, disp_value};
        `OAFP_REG_SWITCH: s_axi_rdata <= {24'h0, config_switch_bank};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;
endmodule : oafp_top

// File: verif/oafp_top_sva.sv
// concurrent checks on the front panel controller ports
module oafp_top_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic [2:0] alarm_led,
  input wire logic buzzer,
  input wire logic [2:0] alarm_relay,
  input wire logic [3:0] disp_mode,
  input wire logic [7:0] disp_suffix
);
  // --------
  // display, alarm and bus properties
  // --------
  localparam int LIM = 1000;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_blink;
    disp_mode == oafp_pkg::disp_dashes |-> alarm_led == 3'b000 || alarm_led == 3'b111;
  endproperty
  a_blink: assert property (p_blink) else $error("boot leds not in step");
  property p_sw_after_boot;
    $past(disp_mode) == oafp_pkg::disp_dashes && disp_mode != oafp_pkg::disp_dashes
      |-> disp_mode == oafp_pkg::disp_switches;
  endproperty
  a_sw_after_boot: assert property (p_sw_after_boot) else $error("no switch view");
  property p_o2_after;
    $rose(disp_mode == oafp_pkg::disp_switches) |-> ##[1:LIM] disp_mode == oafp_pkg::disp_o2;
  endproperty
  a_o2_after: assert property (p_o2_after) else $error("oxygen view late");
  property p_dir_brief;
    $rose(disp_mode == oafp_pkg::disp_dir) |-> ##[1:LIM] disp_mode != oafp_pkg::disp_dir;
  endproperty
  a_dir_brief: assert property (p_dir_brief) else $error("direction view stuck");
  property p_cal;
    $rose(disp_mode == oafp_pkg::disp_cal) |-> ##[1:LIM] disp_mode == oafp_pkg::disp_o2;
  endproperty
  a_cal: assert property (p_cal) else $error("banner stuck");
  property p_halt;
    disp_mode == oafp_pkg::disp_halt |=> disp_mode == oafp_pkg::disp_halt && $stable(alarm_relay);
  endproperty
  a_halt: assert property (p_halt) else $error("halt left");
  property p_set_led;
    disp_mode == oafp_pkg::disp_setpoint |-> alarm_led != 3'b000;
  endproperty
  a_set_led: assert property (p_set_led) else $error("set mode without led");
  property p_suffix;
    disp_mode == oafp_pkg::disp_setpoint |-> disp_suffix inside {8'h48, 8'h4c};
  endproperty
  a_suffix: assert property (p_suffix) else $error("bad direction letter");
  property p_no_suffix;
    disp_mode == oafp_pkg::disp_o2 |-> disp_suffix == 8'h00;
  endproperty
  a_no_suffix: assert property (p_no_suffix) else $error("letter on oxygen view");
  property p_alarm;
    $rose(|alarm_relay) |-> ##[0:2] buzzer && (alarm_led & alarm_relay) == alarm_relay;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm without led or buzzer");
  property p_bresp_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");
endmodule : oafp_top_sva

bind oafp_top oafp_top_sva u_sva (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .alarm_led(alarm_led), .buzzer(buzzer),
  .alarm_relay(alarm_relay), .disp_mode(disp_mode), .disp_suffix(disp_suffix)
);

// File: verif/oafp_operator.sv
// behavioural operator pressing front panel buttons
module oafp_operator (
  input wire logic aclk,
  input wire logic go,
  input wire logic [4:0] keys,
  input wire logic [7:0] hold,
  output logic busy,
  output logic btn_up,
  output logic btn_down,
  output logic [2:0] btn_alarm
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial begin
    busy = 1'b0;
    {btn_up, btn_down, btn_alarm} = 5'h00;
  end
  // hold the keys, then stay off as long so two presses never merge
  always @(posedge aclk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      cnt <= 2 * hold;
      {btn_up, btn_down, btn_alarm} <= keys;
    end else if (busy) begin
      cnt <= cnt - 1;
      if (cnt == hold) {btn_up, btn_down, btn_alarm} <= 5'h00;
      if (cnt == 1) busy <= 1'b0;
    end
  end
endmodule : oafp_operator

// File: verif/tb_oafp_top.sv
// self-checking bench for the front panel controller
`include "oafp_cfg.svh"
module tb_oafp_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned BANNER = 16;
  localparam int unsigned IDLE = 200;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, buzzer, btn_up, btn_down, go, busy, seen;
  logic [7:0] cfg, awaddr, araddr, hold, suffix;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, resp;
  logic [2:0] led, relay, btn_alarm, dir_model;
  logic [4:0] keys;
  logic [3:0] mode;
  logic [15:0] value, o2_hi, saw;
  int mismatches, checked, cycles;
  int sp_model [3];
  int vals [4];
  oafp_top #(.BOOT_CYCLES(64), .BANNER_CYCLES(BANNER), .IDLE_CYCLES(IDLE), .TICK_CYCLES(64)) uut (
    .aclk(aclk), .aresetn(aresetn), .config_switch_bank(cfg), .btn_up(btn_up),
    .btn_down(btn_down), .btn_alarm(btn_alarm), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .alarm_led(led),
    .buzzer(buzzer), .alarm_relay(relay), .disp_mode(mode), .disp_value(value),
    .disp_suffix(suffix));
  oafp_operator op (.aclk(aclk), .go(go), .keys(keys), .hold(hold), .busy(busy),
    .btn_up(btn_up), .btn_down(btn_down), .btn_alarm(btn_alarm));
  // --------
  // clock, watchdog and display history
  // --------
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // brief display states are caught here since tasks may block past them
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (!$isunknown(mode)) saw[mode] <= 1'b1;
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic print_verdict;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  function automatic logic [31:0] pick(input int sel);
    case (sel)
      0: return 32'(mode);
      1: return 32'(relay);
      default: return 32'(value);
    endcase
  endfunction : pick
  // bounded wait on an output, then compare it
  task automatic wait_for(input int sel, input logic [31:0] exp, input int lim, input string w);
    int n;
    n = 0;
    while (n < lim && pick(sel) !== exp) begin
      @(posedge aclk);
      n++;
    end
    chk(w, exp, pick(sel));
  endtask : wait_for
  function automatic logic [2:0] alarm_exp(input int v);
    for (int i = 0; i < 3; i++) alarm_exp[i] = dir_model[i] ? v > sp_model[i] : v < sp_model[i];
  endfunction : alarm_exp
  // --------
  // bus and button drivers
  // --------
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_read
  // keys are {up, down, alarm3, alarm2, alarm1}
  task automatic press(input logic [4:0] k);
    keys <= k;
    hold <= 8'h14;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    do @(posedge aclk); while (busy === 1'b1);
  endtask : press
  // --------
  // main sequence
  // --------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, go, seen} = 8'h00;
    {awaddr, araddr, wdata, keys, hold, saw} = '0;
    cfg = 8'h20;
    void'($urandom(32'hc8ca7677));
    sp_model = '{200, 200, 200};
    dir_model = 3'b000;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (60) begin
      @(posedge aclk);
      if (led === 3'b111) seen = 1'b1;
    end
    chk("boot blink", 1, seen);
    wait_for(0, oafp_pkg::disp_switches, 100, "switch view");
    wait_for(0, oafp_pkg::disp_o2, 300, "oxygen view");
    for (int i = 0; i < 3; i++) begin
      axi_read(8'(`OAFP_REG_SP0 + 4 * i));
      chk("default set point", 32'(sp_model[i]), rd);
    end
    axi_read(`OAFP_REG_DIR);
    chk("default direction", 32'(dir_model), rd);
    axi_read(8'h40);
    chk("unmapped resp", 2'h2, resp);
    chk("unmapped data", 0, rd);
    press(5'b00001);
    wait_for(0, oafp_pkg::disp_setpoint, 40, "set mode");
    chk("set led", 3'b001, led);
    chk("low letter", 8'h4c, suffix);
    for (int i = 0; i < 3; i++) begin
      press(i == 2 ? 5'b01000 : 5'b10000);
      sp_model[0] += (i == 2) ? -1 : 1;
      chk("stepped set point", 32'(sp_model[0]), value);
    end
    saw <= '0;
    press(5'b11000);
    dir_model[0] = 1'b1;
    chk("direction shown", 1, saw[oafp_pkg::disp_dir]);
    chk("high letter", 8'h48, suffix);
    press(5'b00001);
    wait_for(0, oafp_pkg::disp_o2, 40, "leave set mode");
    chk("led off", 3'b000, led);
    axi_read(`OAFP_REG_SP0);
    chk("stored set point", 32'(sp_model[0]), rd);
    axi_read(`OAFP_REG_DIR);
    chk("stored direction", 32'(dir_model), rd);
    o2_hi = 16'hca + 16'($urandom_range(0, 15));
    vals = '{int'(o2_hi), 200, 199, 200};
    foreach (vals[i]) begin
      axi_write(`OAFP_REG_O2, 32'(vals[i]));
      wait_for(1, alarm_exp(vals[i]), 20, "relay");
      chk("alarm led", alarm_exp(vals[i]), led);
      chk("buzzer", |alarm_exp(vals[i]), buzzer);
    end
    cfg <= 8'h00;
    axi_write(`OAFP_REG_O2, 32'(o2_hi));
    wait_for(1, 3'b001, 20, "manual relay");
    axi_write(`OAFP_REG_O2, 32'd200);
    axi_read(`OAFP_REG_STATUS);
    chk("manual hold", 3'b001, relay);
    press(5'b00001);
    chk("silenced", 1'b0, buzzer);
    press(5'b00001);
    chk("manual cleared relay", 3'b000, relay);
    chk("manual cleared led", 3'b000, led);
    press(5'b00010);
    wait_for(0, oafp_pkg::disp_setpoint, 40, "set mode two");
    wait_for(0, oafp_pkg::disp_o2, IDLE + 100, "idle return");
    chk("idle led", 3'b000, led);
    saw <= '0;
    press(5'b11100);
    chk("warm boot dashes", 1, saw[oafp_pkg::disp_dashes]);
    wait_for(0, oafp_pkg::disp_o2, 400, "warm boot end");
    axi_write(`OAFP_REG_CTRL, 32'h8);
    wait_for(0, oafp_pkg::disp_cal, 20, "banner");
    wait_for(0, oafp_pkg::disp_o2, BANNER + 20, "banner end");
    axi_write(`OAFP_REG_CTRL, 32'h3);
    wait_for(0, oafp_pkg::disp_low_battery_message, 20, "low battery");
    axi_write(`OAFP_REG_CTRL, 32'h7);
    wait_for(0, oafp_pkg::disp_halt, 20, "halt");
    press(5'b00001);
    chk("halt kept", oafp_pkg::disp_halt, mode);
    chk("halt led", 3'b000, led);
    print_verdict();
  end
endmodule : tb_oafp_top
